// ### core/seep_core.v
// command, sequencing and storage logic of the serial word memory
`timescale 1ns/1ns
`include "seep_defines.vh"
module seep_core #(
  parameter PROGRAM_CYCLES = `SEEP_PROGRAM_CYCLES
) (
  input wire i_mclk,
  input wire i_rst_n,
  input wire i_chip_select,
  input wire i_serial_clock_in,
  input wire i_serial_data_in,
  output reg o_serial_data_out,
  output reg o_serial_data_oe,
  output reg o_busy
);

  // ==========================================
  // input synchronisers
  reg [1:0] cs_sync;
  reg [1:0] sk_sync;
  reg [1:0] di_sync;
  reg sk_prev;
  reg cs_prev;
  wire cs = cs_sync[1];
  wire sk_rise = sk_sync[1] & ~sk_prev;
  wire cs_fall = cs_prev & ~cs;

  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      cs_sync <= 2'h0;
      sk_sync <= 2'h0;
      di_sync <= 2'h0;
      sk_prev <= 1'b0;
      cs_prev <= 1'b0;
    end else begin
      cs_sync <= {cs_sync[0], i_chip_select};
      sk_sync <= {sk_sync[0], i_serial_clock_in};
      di_sync <= {di_sync[0], i_serial_data_in};
      sk_prev <= sk_sync[1];
      cs_prev <= cs_sync[1];
    end
  end

  // ==========================================
  // storage array
  reg [`SEEP_WORD_W-1:0] mem [0:`SEEP_DEPTH-1];

  // ==========================================
  // command state machine
  localparam ST_IDLE = 6'h01;
  localparam ST_OP = 6'h02;
  localparam ST_ADDR = 6'h04;
  localparam ST_DATA = 6'h08;
  localparam ST_READ = 6'h10;
  localparam ST_DONE = 6'h20;

  localparam PK_NONE = 3'h0;
  localparam PK_WRITE = 3'h1;
  localparam PK_ERASE = 3'h2;
  localparam PK_WRALL = 3'h3;
  localparam PK_ERALL = 3'h4;

  reg [5:0] state;
  reg [1:0] opcode;
  reg [`SEEP_ADDR_W-1:0] addr;
  reg [`SEEP_WORD_W-1:0] shreg;
  reg [`SEEP_CNT_W-1:0] cnt;
  reg prog_en;
  reg [2:0] pend;
  reg ready_shown;

  // program engine
  reg prog_busy;
  reg [2:0] prog_kind;
  reg [`SEEP_ADDR_W-1:0] prog_addr;
  reg [`SEEP_WORD_W-1:0] prog_word;
  reg [31:0] prog_timer;
  reg [`SEEP_ADDR_W:0] fill_idx;

  // two-entry buffer between array fetch and the read shifter
  reg [`SEEP_WORD_W-1:0] buf_data [0:1];
  reg buf_wp;
  reg buf_rp;
  reg [1:0] buf_cnt;
  reg [`SEEP_ADDR_W-1:0] fetch_addr;
  reg fetch_on;
  wire buf_in_valid = fetch_on;
  wire buf_in_ready = (buf_cnt != 2'h2);
  wire buf_out_valid = (buf_cnt != 2'h0);
  reg buf_out_ready;

  function [2:0] seep_kind;
    input [1:0] op;
    input [1:0] ext;
    begin
      case (op)
        `SEEP_OP_WRITE: seep_kind = PK_WRITE;
        `SEEP_OP_ERASE: seep_kind = PK_ERASE;
        `SEEP_OP_EXT: begin
          if (ext == `SEEP_EXT_WRALL)
            seep_kind = PK_WRALL;
          else if (ext == `SEEP_EXT_ERALL)
            seep_kind = PK_ERALL;
          else
            seep_kind = PK_NONE;
        end
        default: seep_kind = PK_NONE;
      endcase
    end
  endfunction

  wire [1:0] ext_code = addr[`SEEP_ADDR_W-1:`SEEP_ADDR_W-2];
  wire [`SEEP_ADDR_W-1:0] addr_next = {addr[`SEEP_ADDR_W-2:0], di_sync[1]};
  wire [1:0] ext_next = addr_next[`SEEP_ADDR_W-1:`SEEP_ADDR_W-2];
  wire [2:0] kind_now = seep_kind(opcode, ext_code);

  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state <= ST_IDLE;
      opcode <= 2'h0;
      addr <= {`SEEP_ADDR_W{1'b0}};
      shreg <= {`SEEP_WORD_W{1'b0}};
      cnt <= {`SEEP_CNT_W{1'b0}};
      prog_en <= `SEEP_PROG_EN_RST;
      pend <= PK_NONE;
      ready_shown <= 1'b0;
      o_serial_data_out <= 1'b0;
      o_serial_data_oe <= 1'b0;
      fetch_on <= 1'b0;
      fetch_addr <= {`SEEP_ADDR_W{1'b0}};
      buf_out_ready <= 1'b0;
    end else begin
      buf_out_ready <= 1'b0;
      if (!cs || prog_busy) begin
        // standby or programming: inputs ignored
        state <= ST_IDLE;
        cnt <= {`SEEP_CNT_W{1'b0}};
        fetch_on <= 1'b0;
        if (!cs) begin
          o_serial_data_oe <= 1'b0;
          ready_shown <= 1'b0;
        end else begin
          // busy poll drives low
          o_serial_data_oe <= 1'b1;
          o_serial_data_out <= 1'b0;
        end
      end else begin
        if (state == ST_IDLE && ready_shown == 1'b0
            && prog_kind != PK_NONE) begin
          // first cycle selected after a program: ready high,
          // also turns a busy-low poll into ready when programming ends
          o_serial_data_oe <= 1'b1;
          o_serial_data_out <= 1'b1;
          ready_shown <= 1'b1;
        end
        if (sk_rise) begin
          case (state)
            ST_IDLE: begin
              if (di_sync[1]) begin
                state <= ST_OP;
                cnt <= {`SEEP_CNT_W{1'b0}};
                o_serial_data_oe <= 1'b0;
              end
            end
            ST_OP: begin
              opcode <= {opcode[0], di_sync[1]};
              if (cnt == 5'h1) begin
                state <= ST_ADDR;
                cnt <= {`SEEP_CNT_W{1'b0}};
              end else begin
                cnt <= cnt + 5'h1;
              end
            end
            ST_ADDR: begin
              addr <= addr_next;
              cnt <= cnt + 5'h1;
              if (cnt == `SEEP_ADDR_W - 1) begin
                cnt <= {`SEEP_CNT_W{1'b0}};
                if (opcode == `SEEP_OP_READ) begin
                  state <= ST_READ;
                  o_serial_data_oe <= 1'b1;
                  o_serial_data_out <= 1'b0;
                  fetch_on <= 1'b1;
                  fetch_addr <= addr_next;
                  cnt <= 5'h10;
                end else if (opcode == `SEEP_OP_EXT &&
                             ext_next == `SEEP_EXT_ENABLE) begin
                  prog_en <= 1'b1;
                  state <= ST_DONE;
                end else if (opcode == `SEEP_OP_EXT &&
                             ext_next == `SEEP_EXT_DISABLE) begin
                  prog_en <= 1'b0;
                  state <= ST_DONE;
                end else if (opcode == `SEEP_OP_WRITE ||
                             (opcode == `SEEP_OP_EXT &&
                              ext_next == `SEEP_EXT_WRALL)) begin
                  state <= ST_DATA;
                end else begin
                  state <= ST_DONE;
                end
              end
            end
            ST_DATA: begin
              // keeps the last sixteen bits shifted in
              shreg <= {shreg[`SEEP_WORD_W-2:0], di_sync[1]};
              if (cnt != 5'h10)
                cnt <= cnt + 5'h1;
            end
            ST_READ: begin
              if (cnt == 5'h10) begin
                // load next word from the buffer, shift its msb
                if (buf_out_valid) begin
                  o_serial_data_out <= buf_data[buf_rp][`SEEP_WORD_W-1];
                  shreg <= {buf_data[buf_rp][`SEEP_WORD_W-2:0], 1'b0};
                  buf_out_ready <= 1'b1;
                  cnt <= 5'h1;
                end
              end else begin
                o_serial_data_out <= shreg[`SEEP_WORD_W-1];
                shreg <= {shreg[`SEEP_WORD_W-2:0], 1'b0};
                cnt <= cnt + 5'h1;
              end
            end
            default: state <= state;
          endcase
        end
        // fetch ahead into the buffer with wrap
        if (fetch_on && buf_in_ready)
          fetch_addr <= fetch_addr + 8'h1;
      end
      // programming armed by the full command, launched on deselect
      if (cs && !prog_busy && state == ST_DONE)
        pend <= prog_en ? kind_now : PK_NONE;
      else if (cs && !prog_busy && state == ST_DATA && cnt == 5'h10)
        pend <= prog_en ? kind_now : PK_NONE;
      else if (cs_fall || (cs && state != ST_DONE && state != ST_DATA))
        pend <= PK_NONE;
    end
  end

  // ==========================================
  // two-entry buffer
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      buf_wp <= 1'b0;
      buf_rp <= 1'b0;
      buf_cnt <= 2'h0;
    end else if (!fetch_on) begin
      buf_wp <= 1'b0;
      buf_rp <= 1'b0;
      buf_cnt <= 2'h0;
    end else begin
      if (buf_in_valid && buf_in_ready) begin
        buf_data[buf_wp] <= mem[fetch_addr];
        buf_wp <= ~buf_wp;
      end
      if (buf_out_ready && buf_out_valid)
        buf_rp <= ~buf_rp;
      buf_cnt <= buf_cnt + {1'b0, buf_in_valid & buf_in_ready}
                 - {1'b0, buf_out_ready & buf_out_valid};
    end
  end

  // ==========================================
  // self-timed programming engine
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      prog_busy <= 1'b0;
      prog_kind <= PK_NONE;
      prog_addr <= {`SEEP_ADDR_W{1'b0}};
      prog_word <= {`SEEP_WORD_W{1'b0}};
      prog_timer <= 32'h0;
      fill_idx <= {(`SEEP_ADDR_W+1){1'b0}};
      o_busy <= 1'b0;
    end else if (!prog_busy) begin
      if (cs_fall && pend != PK_NONE) begin
        prog_busy <= 1'b1;
        o_busy <= 1'b1;
        prog_kind <= pend;
        prog_addr <= addr;
        prog_word <= (pend == PK_ERASE || pend == PK_ERALL) ?
                     `SEEP_ERASED_WORD : shreg;
        prog_timer <= 32'h0;
        fill_idx <= {(`SEEP_ADDR_W+1){1'b0}};
      end
    end else begin
      if (prog_kind == PK_WRITE || prog_kind == PK_ERASE) begin
        if (fill_idx == 9'h0)
          mem[prog_addr] <= prog_word;
        fill_idx <= 9'h1;
      end else if (fill_idx != `SEEP_DEPTH) begin
        mem[fill_idx[`SEEP_ADDR_W-1:0]] <= prog_word;
        fill_idx <= fill_idx + 9'h1;
      end
      prog_timer <= prog_timer + 32'h1;
      if (prog_timer == PROGRAM_CYCLES - 1) begin
        prog_busy <= 1'b0;
        o_busy <= 1'b0;
      end
    end
  end

endmodule // seep_core

// ### pkg/seep_defines.vh
// constants for the serial word memory command block
`ifndef SEEP_DEFINES_VH
`define SEEP_DEFINES_VH
// ==========================================
// geometry
`define SEEP_ADDR_W 8
`define SEEP_WORD_W 16
`define SEEP_DEPTH 256
`define SEEP_CNT_W 5
// ==========================================
// opcodes, two bits after the start bit
`define SEEP_OP_EXT 2'h0
`define SEEP_OP_WRITE 2'h1
`define SEEP_OP_READ 2'h2
`define SEEP_OP_ERASE 2'h3
// extended codes in the two top address bits
`define SEEP_EXT_DISABLE 2'h0
`define SEEP_EXT_WRALL 2'h1
`define SEEP_EXT_ERALL 2'h2
`define SEEP_EXT_ENABLE 2'h3
// ==========================================
// erased word and reset values
`define SEEP_ERASED_WORD 16'hffff
`define SEEP_PROG_EN_RST 1'b0
// ==========================================
// timing, clock period 50 ns
`define SEEP_CLK_NS 50
`define SEEP_PROGRAM_TIME_MS 10
`define SEEP_DESELECT_GAP_US 0.2
`define SEEP_PROGRAM_CYCLES ((`SEEP_PROGRAM_TIME_MS * 1000000) / `SEEP_CLK_NS)
`endif

// ### sim/seep_chk.sv
// checker of the serial word memory command block
`timescale 1ns/1ns
module seep_chk #(
  parameter PROGRAM_CYCLES = 50
) (
  input wire i_mclk,
  input wire i_rst_n,
  input wire i_chip_select,
  input wire i_serial_clock_in,
  input wire i_serial_data_in,
  input wire o_serial_data_out,
  input wire o_serial_data_oe,
  input wire o_busy
);
  // ==========
  // busy length and properties
  integer bcnt;
  always @(posedge i_mclk)
    if (!i_rst_n || !o_busy) bcnt <= 0;
    else bcnt <= bcnt + 1;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  standby_oe_a: assert property (!i_chip_select [*6] |->
    !o_serial_data_oe) else $error("driven while deselected");
  idle_quiet_a: assert property (!i_chip_select &&
    !o_serial_data_oe |=> !o_serial_data_oe) else $error("woke in standby");
  sel_no_prog_a: assert property (i_chip_select [*6] |->
    !$rose(o_busy)) else $error("program began while selected");
  prog_on_fall_a: assert property ($rose(o_busy) |->
    !i_chip_select && $past(i_chip_select, 6)) else $error("bad start");
  busy_dout_a: assert property (o_busy && $past(o_busy) &&
    o_serial_data_oe |-> !o_serial_data_out) else $error("busy not low");
  busy_lock_a: assert property ((o_busy && i_chip_select) [*6] |->
    o_serial_data_oe) else $error("input taken while busy");
  busy_len_a: assert property ($fell(o_busy) |->
    bcnt >= PROGRAM_CYCLES - 1 && bcnt <= PROGRAM_CYCLES + 1)
    else $error("program length off");
  ready_done_a: assert property ($fell(o_busy) && i_chip_select |->
    ##[0:4] (o_serial_data_out || !i_chip_select)) else $error("no ready");
  cover property ($rose(o_busy));
  cover property ($fell(o_busy) && i_chip_select);
  cover property ($rose(o_serial_data_oe) && !o_busy);
endmodule // seep_chk
bind seep_core seep_chk #(.PROGRAM_CYCLES(PROGRAM_CYCLES)) u_seep_chk (
  .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_chip_select(i_chip_select),
  .i_serial_clock_in(i_serial_clock_in), .i_serial_data_in(i_serial_data_in),
  .o_serial_data_out(o_serial_data_out), .o_serial_data_oe(o_serial_data_oe),
  .o_busy(o_busy));

// ### sim/seep_host.sv
// host model driving select, serial clock and data-in
`timescale 1ns/1ns
module seep_host (
  input wire i_mclk,
  input wire i_dout,
  output reg o_cs,
  output reg o_sk,
  output reg o_di
);
  // ==========
  // serial frames
  reg [63:0] rd;
  initial begin
    o_cs = 1'b0;
    o_sk = 1'b0;
    o_di = 1'b0;
    rd = 64'h0;
  end
  task tick(input integer n);
    repeat (n) @(posedge i_mclk);
  endtask
  // data-in changes while the clock is low, read back before each rise
  task bits(input integer n, input [31:0] v);
    integer i;
    for (i = n - 1; i >= 0; i = i - 1) begin
      o_sk <= 1'b0;
      o_di <= v[i];
      tick(4);
      rd <= {rd[62:0], i_dout};
      o_sk <= 1'b1;
      tick(4);
    end
  endtask
  // data-in held low while selected idle, gap after deselect
  task sel(input v);
    o_cs <= v;
    o_sk <= 1'b0;
    o_di <= 1'b0;
    tick(v ? 4 : 6);
  endtask
endmodule // seep_host

// ### sim/tb.sv
// self-checking bench of the serial word memory command block
`timescale 1ns/1ns
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin \
  miscompares++; $display("wrong value at %0t: %h %h", $time, a, e); end end
module tb;
  // ==========
  // harness
  // above the array depth, so an all-words fill finishes while busy
  localparam int PC = 300;
  reg mclk = 1'b0;
  reg rst_n = 1'b0;
  wire cs, sk, di, dout, oe, busy, dpin;
  integer miscompares = 0;
  integer check_count = 0;
  integer cyc = 0;
  // released data-out shows the inverse of its last value
  assign dpin = oe ? dout : ~dout;
  seep_core #(.PROGRAM_CYCLES(PC)) u_seep_core (.i_mclk(mclk),
    .i_rst_n(rst_n), .i_chip_select(cs), .i_serial_clock_in(sk),
    .i_serial_data_in(di), .o_serial_data_out(dout),
    .o_serial_data_oe(oe), .o_busy(busy));
  seep_host u_seep_host (.i_mclk(mclk), .i_dout(dpin), .o_cs(cs),
    .o_sk(sk), .o_di(di));
  initial forever #25 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      finish_test;
    end
  end
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // host calls go through these wrappers
  task set_sel(input v);
    u_seep_host.sel(v);
  endtask
  task send(input integer n, input [31:0] v);
    u_seep_host.bits(n, v);
  endtask
  task wait_cyc(input integer n);
    repeat (n) @(posedge mclk);
  endtask
  task cmd(input integer n, input [31:0] v);
    set_sel(1'b1);
    send(n, v);
    set_sel(1'b0);
  endtask
  task poll(input e);
    set_sel(1'b1);
    wait_cyc(2);
    `CHK({oe, dpin}, {1'b1, e})
  endtask
  // host waits out programming before the next command
  task wait_prog;
    integer n;
    n = 0;
    `CHK(busy, 1'b1)
    while (busy === 1'b1 && n < PC + 9) begin
      @(posedge mclk);
      n++;
    end
    wait_cyc(4);
    `CHK(busy, 1'b0)
  endtask
  task rdw(input [7:0] a, input integer n, input rdy);
    set_sel(1'b1);
    wait_cyc(2);
    if (rdy) `CHK({oe, dpin}, 2'b11)
    send(1, 1);
    wait_cyc(2);
    if (rdy) `CHK(oe, 1'b0)
    send(10, {2'b10, a});
    send(16 * n + 1, 0);
    set_sel(1'b0);
  endtask
  // ==========
  // scenarios
  task t_guard;
    cmd(27, {3'b101, 8'h10, 16'h0000});
    wait_cyc(10);
    `CHK(busy, 1'b0)
    $display("test guard done");
  endtask
  task t_erase_all_words;
    cmd(11, {3'b100, 8'hc0});
    cmd(11, {3'b100, 8'h80});
    poll(1'b0);
    wait_prog;
    `CHK({oe, dpin}, 2'b11)
    set_sel(1'b0);
    poll(1'b1);
    set_sel(1'b0);
    $display("test erase all done");
  endtask
  task t_write;
    set_sel(1'b1);
    send(2, 0);
    send(31, {3'b101, 8'hff, 4'ha, 16'h5a3c});
    set_sel(1'b0);
    cmd(11, {3'b111, 8'hff});
    wait_prog;
    rdw(8'hff, 2, 1'b1);
    `CHK(u_seep_host.rd[32:0], {1'b0, 16'h5a3c, 16'hffff})
    $display("test write done");
  endtask
  task t_erase;
    cmd(27, {3'b100, 8'h40, 16'h1234});
    wait_prog;
    cmd(11, {3'b111, 8'hff});
    wait_prog;
    rdw(8'hfe, 3, 1'b1);
    `CHK(u_seep_host.rd[48:0], {17'h01234, 16'hffff, 16'h1234})
    cmd(11, {3'b100, 8'h00});
    cmd(27, {3'b101, 8'h00, 16'h0000});
    wait_cyc(10);
    `CHK(busy, 1'b0)
    $display("test erase done");
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    wait_cyc(4);
    t_guard;
    t_erase_all_words;
    t_write;
    t_erase;
    finish_test;
  end
endmodule // tb
